// ### include/pmrc_pkg.sv
// pmrc_pkg: register offsets, field positions and reset values for the
// regulator control register slice. assumes a byte-wide register port.
package pmrc_pkg;
  localparam int PMRC_AW = 8;
  localparam int PMRC_DW = 8;
  localparam logic [7:0] PMRC_REG2_VOLT_ADDR = 8'h05;
  localparam logic [7:0] PMRC_REG3_VOLT_ADDR = 8'h06;
  localparam logic [7:0] PMRC_REG4_VOLT_ADDR = 8'h07;
  localparam logic [7:0] PMRC_ILIM_ADDR = 8'h08;
  localparam logic [7:0] PMRC_MODE_EN_ADDR = 8'h09;
  localparam logic [7:0] PMRC_STEP_UP_EN_ADDR = 8'h0A;
  localparam logic [7:0] PMRC_VOLT_RST = 8'h00;
  localparam logic [7:0] PMRC_ILIM_RST = 8'h55;
  localparam logic [7:0] PMRC_MODE_EN_RST = 8'h00;
  localparam logic [7:0] PMRC_STEP_UP_EN_RST = 8'h00;
  // writable bits; others read as zero
  localparam logic [7:0] PMRC_VOLT_MASK = 8'h7F;
  localparam logic [7:0] PMRC_ILIM_MASK = 8'h55;
  localparam logic [7:0] PMRC_MODE_EN_MASK = 8'hDF;
  localparam int PMRC_STEP_UP_MODE_BIT = 7;
  localparam int PMRC_STEP_DOWN_MODE_BIT = 6;
  localparam int PMRC_STEP_DOWN_EN_BIT = 4;
  localparam int PMRC_SLOT_W = 3;
  localparam logic [2:0] PMRC_SLOT_BUS = 3'h0;
  // voltage code map: mv = base + step * (code - first)
  localparam logic [6:0] PMRC_VCODE_DEFAULT = 7'h00;
  localparam logic [6:0] PMRC_VCODE_FIRST = 7'h0F;
  localparam logic [6:0] PMRC_VCODE_LAST = 7'h73;
  localparam int PMRC_VBASE_MV = 800;
  localparam int PMRC_VSTEP_MV = 25;
  localparam logic [11:0] PMRC_ILIM_LOW_MA = 12'h096;
  localparam logic [11:0] PMRC_ILIM_HIGH_MA = 12'h168;

  typedef struct packed {
    logic step_up_force_pwm;
    logic step_down_force_pwm;
    logic step_up_on;
    logic step_down_on;
    logic [3:0] regulator_on;
  } pmrc_rail_ctrl_s;

  typedef struct packed {
    logic [PMRC_SLOT_W-1:0] step_down;
    logic [3:0][PMRC_SLOT_W-1:0] regulator;
  } pmrc_slots_s;
endpackage

// ### verif/pmrc_regs_chk.sv
// checker: port relations of the regulator register slice
// assumes one clock and an async active-high reset
`timescale 1ns/1ns
module pmrc_regs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire pmrc_pkg::pmrc_slots_s slots,
  input wire pmrc_pkg::pmrc_rail_ctrl_s seq_ctrl,
  input wire pmrc_pkg::pmrc_rail_ctrl_s rail_ctrl,
  input wire logic [3:0] regulator_current_limit,
  input wire logic reserved_code_seen
);
  import pmrc_pkg::*;
  logic [3:0] c;
  assign c = regulator_current_limit;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence w9; wr_en && addr == 8'h09 ##1 !wr_en; endsequence
  chk_up_mode: assert property (w9 |=>
    rail_ctrl.step_up_force_pwm == $past(wdata[7], 2)) else $error("up mode");
  chk_dn_mode: assert property (w9 |=>
    rail_ctrl.step_down_force_pwm == $past(wdata[6], 2)) else $error("dn mode");
  chk_dn_bus_on: assert property (w9 ##0 slots.step_down == 3'h0 |=>
    rail_ctrl.step_down_on == $past(wdata[4], 2)) else $error("dn on");
  chk_dn_seq_on: assert property (slots.step_down != 3'h0 |=>
    rail_ctrl.step_down_on == $past(seq_ctrl.step_down_on)) else $error("dn seq");
  chk_reg_seq_on: assert property (slots.regulator[0] != 3'h0 |=>
    rail_ctrl.regulator_on[0] == $past(seq_ctrl.regulator_on[0]))
    else $error("reg seq");
  chk_up_any_bit: assert property (wr_en && addr == 8'h0A ##1 !wr_en |=>
    rail_ctrl.step_up_on == (|$past(wdata, 2))) else $error("up on");
  chk_ilim_read: assert property (rd_en && addr == 8'h08 |=> rdata ==
    {1'b0, $past(c[3]), 1'b0, $past(c[2]), 1'b0, $past(c[1]), 1'b0,
    $past(c[0])}) else $error("ilim read");
  chk_rsv_flag: assert property (wr_en && wdata[6:0] == 7'h74 &&
    addr == 8'h06 ##1 !wr_en |=> reserved_code_seen) else $error("rsv");
  cover property (w9 ##0 slots.step_down == 3'h0);
  cover property (slots.step_down != 3'h0);
  cover property (rd_en && addr == 8'h08);
endmodule

bind pmrc_regs pmrc_regs_chk i_chk (.clk, .rst, .wr_en, .rd_en, .addr,
  .wdata, .rdata, .slots, .seq_ctrl, .rail_ctrl, .regulator_current_limit,
  .reserved_code_seen);

// ### verif/pmrc_regs_tb.sv
// bench for pmrc_regs: strobe reads and writes against expected values
// assumes pmrc_seq_model supplies slot fields and on requests
`timescale 1ns/1ns
module pmrc_regs_tb;
  import pmrc_pkg::*;
  logic clk, rst, wr_en, rd_en, rd_hit, rsv, req;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] sel, ud;
  logic [3:0] ilim;
  logic [2:0][6:0] tv;
  logic [2:0][11:0] mv;
  pmrc_slots_s slots;
  pmrc_rail_ctrl_s seq_ctrl, rail;
  int n_fail = 0, check_count = 0;
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00};
  logic [7:0] wv [6] = '{8'h7F, 8'h7F, 8'h7F, 8'h55, 8'hDF, 8'hFF};
  logic [7:0] vc [4] = '{8'h74, 8'h0F, 8'h73, 8'h00};
  logic [11:0] ve [4] = '{12'h000, 12'h320, 12'hCE4, 12'h000};
  pmrc_regs i_dut (.clk, .rst, .wr_en, .rd_en, .addr, .wdata, .rdata,
    .rd_hit, .slots, .seq_ctrl, .rail_ctrl(rail),
    .regulator_current_limit(ilim), .regulator_target_voltage(tv),
    .regulator_target_mv(mv), .regulator_use_default(ud),
    .reserved_code_seen(rsv));
  pmrc_seq_model i_seq (.sel, .req, .slots, .seq_ctrl);
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [11:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk);
    {rd_en, addr} = {1'b1, a};
    @(negedge clk);
    rd_en = 0;
    chk("rdata", {4'h0, e}, {4'h0, rdata});
    chk("rd_hit", {11'h0, a inside {[8'h05:8'h0A]}}, {11'h0, rd_hit});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // whole run is under a hundred cycles; this leaves ample margin
  initial begin
    #20000;
    n_fail++;
    print_verdict;
  end
  initial begin
    rst = 1;
    {wr_en, rd_en, addr, wdata, sel, req} = '0;
    repeat (20) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 6; i++) begin
      rd(8'h05 + 8'(i), rv[i]);
      wr(8'h05 + 8'(i), 8'hFF);
      rd(8'h05 + 8'(i), wv[i]);
    end
    rd(8'h0B, 8'h00);
    chk("rail", 12'h0FF, {4'h0, rail});
    chk("rsv", 12'h001, {11'h0, rsv});
    wr(8'h09, 8'h00);
    wr(8'h0A, 8'h80);
    rd(8'h0A, 8'h80);
    chk("rail", 12'h020, {4'h0, rail});
    {sel, req} = {3'h3, 1'b1};
    wr(8'h0A, 8'h01);
    rd(8'h09, 8'h00);
    chk("rail", 12'h03F, {4'h0, rail});
    req = 0;
    wr(8'h09, 8'h1F);
    rd(8'h08, 8'h55);
    chk("rail", 12'h020, {4'h0, rail});
    sel = 0;
    wr(8'h08, 8'h14);
    chk("ilim", 12'h006, {8'h0, ilim});
    rd(8'h09, 8'h1F);
    chk("rail", 12'h03F, {4'h0, rail});
    for (int i = 0; i < 4; i++) begin
      wr(8'h06, vc[i]);
      chk("mv", ve[i], mv[1]);
      chk("dflt", {11'h0, vc[i] == 8'h00}, {11'h0, ud[1]});
    end
    wr(8'h05, 8'h0F);
    wr(8'h07, 8'h40);
    @(negedge clk);
    chk("rsv", 12'h000, {11'h0, rsv});
    chk("mv", 12'h7E9, mv[2]);
    chk("code", 12'h040, {5'h0, tv[2]});
    print_verdict;
  end
endmodule

// ### verif/pmrc_seq_model.sv
// sequencer stand-in: slot fields and on requests for the step-down and four regulator rails
// assumes the bench drives sel and req off the sampling edge
`timescale 1ns/1ns
module pmrc_seq_model (
  input wire logic [2:0] sel,
  input wire logic req,
  output pmrc_pkg::pmrc_slots_s slots,
  output pmrc_pkg::pmrc_rail_ctrl_s seq_ctrl
);
  import pmrc_pkg::*;
  assign slots = {5{sel}};
  assign seq_ctrl = {3'h0, {5{req}}};
endmodule

// ### verilog/pmrc_regs.sv
`timescale 1ns/1ns
// pmrc_regs: regulator control register slice (voltage codes, current
// limits, converter modes and enables) of a multi-rail power device.
// assumes a byte-wide register port from the serial interface, one
// cycle strobes, and slot fields supplied by the sequencing registers.
//
// Behaviour
// - regulator target is 0.800 V plus 25 mV per code above 0x0F
// - code zero selects default; 0x01-0x0E, 0x74-0x7F reserved, host avoids
// - current limit bits 6,4,2,0: 150 mA clear, 360 mA set, reset one
// - enable register bit 7: step-up auto PFM/PWM or forced PWM
// - enable register bit 6: step-down auto PFM/PWM or forced PWM
// - step-down enable bit 4 acts only while its slot field is 000
// - regulator enable bits 3..0 act only while their slot field is 000
// - step-up enable register holds eight RW bits, reset to zero
// - slot 000 hands control to the bus bit; 1..7 are power-up slots
module pmrc_regs #(
  parameter int NUM_VREG = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [pmrc_pkg::PMRC_AW-1:0] addr,
  input wire logic [pmrc_pkg::PMRC_DW-1:0] wdata,
  output logic [pmrc_pkg::PMRC_DW-1:0] rdata,
  output logic rd_hit,
  input wire pmrc_pkg::pmrc_slots_s slots,
  input wire pmrc_pkg::pmrc_rail_ctrl_s seq_ctrl,
  output pmrc_pkg::pmrc_rail_ctrl_s rail_ctrl,
  output logic [3:0] regulator_current_limit,
  output logic [NUM_VREG-1:0][6:0] regulator_target_voltage,
  output logic [NUM_VREG-1:0][11:0] regulator_target_mv,
  output logic [NUM_VREG-1:0] regulator_use_default,
  output logic reserved_code_seen
);
  import pmrc_pkg::*;

  if (NUM_VREG != 3) begin : g_bad_count
    $error("pmrc_regs: NUM_VREG must be 3");
  end

  logic [NUM_VREG-1:0][6:0] vout_ff;
  logic [7:0] ilim_ff;
  logic [7:0] mode_en_ff;
  logic [7:0] step_up_en_ff;
  logic [NUM_VREG-1:0] vres;
  logic reserved_ff;
  logic [NUM_VREG-1:0] vwr_hit;
  logic [7:0] nxt_rdata;
  logic nxt_rd_hit;

  // voltage registers sit at consecutive offsets from regulator 2
  for (genvar i = 0; i < NUM_VREG; i++) begin : g_vreg
    assign vwr_hit[i] = wr_en &&
      (addr == 8'(PMRC_REG2_VOLT_ADDR + 8'(i)));

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        vout_ff[i] <= PMRC_VOLT_RST[6:0];
      end else if (vwr_hit[i]) begin
        vout_ff[i] <= wdata[6:0];
      end
    end

    pmrc_vcode u_vcode (
      .code(vout_ff[i]),
      .target_mv(regulator_target_mv[i]),
      .use_default(regulator_use_default[i]),
      .reserved(vres[i])
    );
  end

  assign regulator_target_voltage = vout_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ilim_ff <= PMRC_ILIM_RST;
    end else if (wr_en && addr == PMRC_ILIM_ADDR) begin
      ilim_ff <= wdata & PMRC_ILIM_MASK;
    end
  end

  assign regulator_current_limit = {ilim_ff[6], ilim_ff[4], ilim_ff[2],
                                    ilim_ff[0]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_en_ff <= PMRC_MODE_EN_RST;
    end else if (wr_en && addr == PMRC_MODE_EN_ADDR) begin
      mode_en_ff <= wdata & PMRC_MODE_EN_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_up_en_ff <= PMRC_STEP_UP_EN_RST;
    end else if (wr_en && addr == PMRC_STEP_UP_EN_ADDR) begin
      step_up_en_ff <= wdata;
    end
  end

  // registered note of any reserved code now held; clears once none is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reserved_ff <= 1'b0;
    end else begin
      reserved_ff <= |vres;
    end
  end

  assign reserved_code_seen = reserved_ff;

  // rail outputs registered so the analog side never sees decode glitches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rail_ctrl <= '0;
    end else begin
      rail_ctrl.step_up_force_pwm <= mode_en_ff[PMRC_STEP_UP_MODE_BIT];
      rail_ctrl.step_down_force_pwm <= mode_en_ff[PMRC_STEP_DOWN_MODE_BIT];
      rail_ctrl.step_up_on <= |step_up_en_ff;
      if (slots.step_down == PMRC_SLOT_BUS) begin
        rail_ctrl.step_down_on <= mode_en_ff[PMRC_STEP_DOWN_EN_BIT];
      end else begin
        rail_ctrl.step_down_on <= seq_ctrl.step_down_on;
      end
      for (int r = 0; r < 4; r++) begin
        if (slots.regulator[r] == PMRC_SLOT_BUS) begin
          rail_ctrl.regulator_on[r] <= mode_en_ff[r];
        end else begin
          rail_ctrl.regulator_on[r] <= seq_ctrl.regulator_on[r];
        end
      end
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    nxt_rd_hit = 1'b1;
    case (addr)
      PMRC_REG2_VOLT_ADDR: nxt_rdata = {1'b0, vout_ff[0]};
      PMRC_REG3_VOLT_ADDR: nxt_rdata = {1'b0, vout_ff[1]};
      PMRC_REG4_VOLT_ADDR: nxt_rdata = {1'b0, vout_ff[2]};
      PMRC_ILIM_ADDR: nxt_rdata = ilim_ff;
      PMRC_MODE_EN_ADDR: nxt_rdata = mode_en_ff;
      PMRC_STEP_UP_EN_ADDR: nxt_rdata = step_up_en_ff;
      default: nxt_rd_hit = 1'b0;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      rd_hit <= 1'b0;
    end else if (rd_en) begin
      rdata <= nxt_rdata;
      rd_hit <= nxt_rd_hit;
    end
  end
endmodule

// ### verilog/pmrc_vcode.sv
`timescale 1ns/1ns
// pmrc_vcode: decodes one 7-bit regulator voltage code into millivolts.
// assumes the code comes from a register; purely combinational.
module pmrc_vcode (
  input wire logic [6:0] code,
  output logic [11:0] target_mv,
  output logic use_default,
  output logic reserved
);
  import pmrc_pkg::*;

  logic [11:0] offs;

  always_comb begin
    offs = 12'(code - PMRC_VCODE_FIRST);
    use_default = (code == PMRC_VCODE_DEFAULT);
    reserved = !use_default &&
               ((code < PMRC_VCODE_FIRST) || (code > PMRC_VCODE_LAST));
    if (use_default || reserved) begin
      target_mv = 12'h000;
    end else begin
      target_mv = 12'(PMRC_VBASE_MV) + 12'(offs * 12'(PMRC_VSTEP_MV));
    end
  end
endmodule
